/* verilog/adc_conversion_and_readout.sv */
`timescale 1ns/100ps
module adc_conversion_and_readout #(
  parameter int CH = adc_pkg::CHANNELS,
  parameter int RAW_W = 26,
  parameter int SETTLE_HR = adc_pkg::SETTLE_HR,
  parameter int SETTLE_LP = adc_pkg::SETTLE_LP
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic din,
  output logic dout,
  output logic doutEn,
  output logic resultReadyN,
  input wire logic startPin,
  input wire logic oneShotSel,
  input wire logic readbackEn,
  input wire logic lowPowerSel,
  input wire logic [2:0] rateSelect,
  input wire logic [adc_pkg::FLAG_W-1:0] leadoffPosFlags,
  input wire logic [adc_pkg::FLAG_W-1:0] leadoffNegFlags,
  input wire logic [adc_pkg::FLAG_W-1:0] gpioStatus,
  input wire logic [CH*RAW_W-1:0] chanRaw,
  input wire logic [CH-1:0] chanPowerDown,
  output logic filterReset,
  output logic converting
);
  localparam int AW = (CH > 1) ? $clog2(CH) : 1;

  typedef struct packed {
    adc_pkg::conv_state_t state;
    logic [15:0] cnt;
    logic [AW-1:0] wrIdx;
    logic [3:0] prevLvl;
    logic stopPend;
    logic readyN;
    logic filtRst;
    logic busy;
    logic [adc_pkg::STATUS_W-1:0] status;
    logic shortW;
  } ctl_t;

  typedef struct packed {
    logic [4:0] bitCnt;
    logic [4:0] wordIdx;
    logic [23:0] shiftR;
    logic dout;
    logic doutEn;
    logic done;
  } tx_t;

  typedef struct packed {
    logic [2:0] fallCnt;
    logic [5:0] cmdBits;
  } rx_t;

  ctl_t r_r, r_nxt;
  tx_t t_r, t_nxt;
  rx_t c_r, c_nxt;

  logic [2:0] linkFlag;
  logic [2:0] setFlag;
  logic [3:0] lvl;
  logic [3:0] ev;
  logic startEv, stopEv;
  logic wrEn;
  logic [23:0] wrData;
  logic [23:0] rdData;
  logic [AW-1:0] rdAddr;
  logic [15:0] settleM1, periodM1;
  logic signed [RAW_W-1:0] rawSel;
  logic [23:0] word;
  logic [4:0] wordLen;

  function automatic logic [15:0] settleCycles(input logic lp, input logic [2:0] rate);
    int sh;
    int base;
    sh = (rate > 3'(adc_pkg::RATE_SHIFT_MAX)) ? adc_pkg::RATE_SHIFT_MAX : int'(rate);
    base = lp ? SETTLE_LP : SETTLE_HR;
    return 16'(base << sh);
  endfunction

  function automatic logic opMatch(input logic [6:0] bits, input logic [6:0] op);
    return bits == op;
  endfunction

  function automatic logic [23:0] shapeResult(input logic signed [RAW_W-1:0] v,
                                             input logic off, input logic [2:0] rate);
    logic [23:0] res;
    logic [23:0] mask;
    mask = 24'hffffff;
    if (v > $signed({{(RAW_W-24){1'b0}}, adc_pkg::SAT_MAX})) begin
      res = adc_pkg::SAT_MAX;
    end else if (v < $signed({{(RAW_W-24){1'b1}}, adc_pkg::SAT_MIN})) begin
      res = adc_pkg::SAT_MIN;
    end else begin
      res = v[23:0];
    end
    if (rate == adc_pkg::RATE_R0) begin
      mask = ~((24'h1 << adc_pkg::TRAIL_R0) - 24'h1);
    end else if (rate == adc_pkg::RATE_R1) begin
      mask = ~((24'h1 << adc_pkg::TRAIL_R1) - 24'h1);
    end
    return off ? 24'h0 : (res & mask);
  endfunction

  // One synchroniser for the start pin and the three serial-side flags
  level_sync #(.W(4)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async({startPin, linkFlag}),
    .level(lvl)
  );

  result_mem #(.W(24), .DEPTH(CH), .AW(AW)) u_mem (
    .wrClk(clk),
    .wrEn(wrEn),
    .wrAddr(r_r.wrIdx),
    .wrData(wrData),
    .rdClk(sclk),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  assign settleM1 = settleCycles(lowPowerSel, rateSelect) - 16'h1;
  assign periodM1 = (settleCycles(lowPowerSel, rateSelect) >> adc_pkg::PERIOD_SHIFT) - 16'h1;
  assign rawSel = chanRaw[int'(r_r.wrIdx)*RAW_W +: RAW_W];
  assign wrData = shapeResult(rawSel, chanPowerDown[r_r.wrIdx], rateSelect);
  assign ev = lvl & ~r_r.prevLvl;
  assign startEv = ev[adc_pkg::EV_PIN] | ev[adc_pkg::EV_START];
  assign stopEv = (~lvl[adc_pkg::EV_PIN] & r_r.prevLvl[adc_pkg::EV_PIN] & ~oneShotSel)
    | ev[adc_pkg::EV_STOP];

  always_comb begin
    r_nxt = r_r;
    wrEn = 1'b0;
    r_nxt.prevLvl = lvl;
    r_nxt.filtRst = 1'b0;
    // Serial falling edge clears ready; a new result this cycle still wins
    if (ev[adc_pkg::EV_FELL] && !r_r.readyN) begin
      r_nxt.readyN = 1'b1;
    end
    unique case (r_r.state)
      adc_pkg::IDLE: begin
        if (startEv) begin
          r_nxt.state = adc_pkg::CONVERT;
          r_nxt.cnt = settleM1;
          r_nxt.readyN = 1'b1;
          r_nxt.filtRst = 1'b1;
          r_nxt.stopPend = 1'b0;
          r_nxt.busy = 1'b1;
        end
      end
      adc_pkg::CONVERT: begin
        if (startEv) begin
          r_nxt.cnt = settleM1;
          r_nxt.filtRst = 1'b1;
          r_nxt.stopPend = 1'b0;
        end else begin
          if (stopEv) begin
            r_nxt.stopPend = 1'b1;
          end
          if (r_r.cnt == 16'h0) begin
            r_nxt.state = adc_pkg::WRITE;
            r_nxt.wrIdx = '0;
          end else begin
            r_nxt.cnt = r_r.cnt - 16'h1;
          end
        end
      end
      adc_pkg::WRITE: begin
        wrEn = 1'b1;
        if (stopEv) begin
          r_nxt.stopPend = 1'b1;
        end
        if (r_r.wrIdx == AW'(CH-1)) begin
          r_nxt.readyN = 1'b0;
          r_nxt.status = {leadoffPosFlags, leadoffNegFlags, gpioStatus};
          r_nxt.shortW = adc_pkg::shortRate(rateSelect);
          if (oneShotSel || r_r.stopPend || stopEv) begin
            r_nxt.state = adc_pkg::IDLE;
            r_nxt.busy = 1'b0;
          end else begin
            r_nxt.state = adc_pkg::CONVERT;
            r_nxt.cnt = periodM1;
          end
        end else begin
          r_nxt.wrIdx = r_r.wrIdx + AW'(1);
        end
      end
    endcase
    // A start in the write phase must not be lost; it restarts the settling count
    if (startEv && r_r.state == adc_pkg::WRITE) begin
      r_nxt.state = adc_pkg::CONVERT;
      r_nxt.cnt = settleM1;
      r_nxt.filtRst = 1'b1;
      r_nxt.stopPend = 1'b0;
      r_nxt.busy = 1'b1;
    end
    if (!reset_n) begin
      r_nxt = '0;
      r_nxt.state = adc_pkg::IDLE;
      r_nxt.readyN = 1'b1;
      r_nxt.prevLvl = 4'hf;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign resultReadyN = r_r.readyN;
  assign filterReset = r_r.filtRst;
  assign converting = r_r.busy;

  // Serial side: next channel is fetched one word ahead of its first bit
  always_comb begin
    rdAddr = '0;
    if (t_r.wordIdx != 5'h0 && t_r.wordIdx <= 5'(CH)) begin
      rdAddr = AW'(t_r.wordIdx - 5'h1);
    end
  end

  always_comb begin
    word = r_r.status;
    wordLen = 5'(adc_pkg::STATUS_W);
    if (t_r.wordIdx != 5'h0 && t_r.wordIdx != 5'(CH+1)) begin
      word = r_r.shortW ? {rdData[23:8], 8'h0} : rdData;
      wordLen = r_r.shortW ? 5'(adc_pkg::SHORT_W) : 5'(adc_pkg::LONG_W);
    end
  end

  always_comb begin
    t_nxt = t_r;
    t_nxt.doutEn = 1'b1;
    if (t_r.done) begin
      t_nxt.dout = 1'b0;
    end else if (t_r.bitCnt == 5'h0) begin
      if (t_r.wordIdx == 5'(CH+1) && !readbackEn) begin
        t_nxt.done = 1'b1;
        t_nxt.dout = 1'b0;
      end else begin
        t_nxt.dout = word[23];
        t_nxt.shiftR = {word[22:0], 1'b0};
        t_nxt.bitCnt = wordLen - 5'h1;
        t_nxt.wordIdx = (t_r.wordIdx == 5'(CH+1)) ? 5'h1 : t_r.wordIdx + 5'h1;
      end
    end else begin
      t_nxt.dout = t_r.shiftR[23];
      t_nxt.shiftR = {t_r.shiftR[22:0], 1'b0};
      t_nxt.bitCnt = t_r.bitCnt - 5'h1;
    end
  end

  // Chip select high holds the transmit and command registers in reset and floats the output
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign dout = t_r.dout;
  assign doutEn = t_r.doutEn;

  always_comb begin
    c_nxt.cmdBits = {c_r.cmdBits[4:0], din};
    c_nxt.fallCnt = c_r.fallCnt + 3'h1;
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign setFlag[adc_pkg::EV_FELL] = 1'b1;
  assign setFlag[adc_pkg::EV_START] = (c_r.fallCnt == 3'(adc_pkg::OPCODE_FALL))
    && opMatch({c_r.cmdBits, din}, adc_pkg::START_OP7);
  assign setFlag[adc_pkg::EV_STOP] = (c_r.fallCnt == 3'(adc_pkg::OPCODE_FALL))
    && opMatch({c_r.cmdBits, din}, adc_pkg::STOP_OP7);

  // Flags are cleared by the acknowledge level; the ready clear ignores chip select
  for (genvar g = 0; g < 3; g++) begin : g_flag
    logic flag_r;
    always_ff @(negedge sclk or posedge r_r.prevLvl[g]) begin
      if (r_r.prevLvl[g]) begin
        flag_r <= 1'b0;
      end else if (setFlag[g]) begin
        flag_r <= 1'b1;
      end
    end
    assign linkFlag[g] = flag_r;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_ready_from_write: assert property (
    $fell(resultReadyN) |-> $past(r_r.state) == adc_pkg::WRITE)
    else $error("ready fell without a completed conversion");
  a_start_ready_high: assert property (
    (r_r.state == adc_pkg::IDLE && startEv) |=> resultReadyN && r_r.state == adc_pkg::CONVERT)
    else $error("start did not raise ready and begin converting");
  a_start_filter_reset: assert property (
    startEv |=> filterReset ##1 !filterReset)
    else $error("start did not pulse filter reset");
  a_sclk_clears_ready: assert property (
    (ev[adc_pkg::EV_FELL] && !r_r.readyN && r_r.state != adc_pkg::WRITE) |=> resultReadyN)
    else $error("serial falling edge did not clear ready");
  a_oneshot_halts: assert property (
    ($fell(resultReadyN) && $past(oneShotSel)) |-> r_r.state == adc_pkg::IDLE)
    else $error("one-shot conversion did not halt");
  a_oneshot_holds: assert property (
    (r_r.state == adc_pkg::IDLE && !resultReadyN && !ev[adc_pkg::EV_FELL] && !startEv)
    |=> !resultReadyN)
    else $error("ready rose without serial clock or start");
  a_stop_finishes: assert property (
    (r_r.state == adc_pkg::CONVERT && stopEv && !startEv && r_r.cnt == 16'h0)
    |=> r_r.state == adc_pkg::WRITE ##[1:8] (r_r.state == adc_pkg::IDLE && !resultReadyN))
    else $error("stopped conversion did not complete and halt");
  a_settle_load: assert property (
    (r_r.state == adc_pkg::IDLE && startEv) |=> r_r.cnt == $past(settleM1))
    else $error("settling count not loaded at start");
  a_powerdown_zero: assert property (
    (r_r.state == adc_pkg::WRITE && chanPowerDown[r_r.wrIdx]) |-> wrData == 24'h0)
    else $error("powered-down channel not zero");

  c_oneshot: cover property (
    r_r.state == adc_pkg::WRITE ##1 (r_r.state == adc_pkg::IDLE && !resultReadyN));
  c_continuous: cover property (
    $fell(resultReadyN) && r_r.state == adc_pkg::CONVERT);
  c_stop_pending: cover property (r_r.state == adc_pkg::CONVERT && stopEv);
  c_start_in_write: cover property (r_r.state == adc_pkg::WRITE && startEv);
  c_opcode_start: cover property (ev[adc_pkg::EV_START] && r_r.state == adc_pkg::IDLE);

  a_readback_wrap: assert property (@(posedge sclk) disable iff (csN)
    (t_r.bitCnt == 5'h0 && t_r.wordIdx == 5'(CH+1) && readbackEn && !t_r.done)
    |=> (t_r.wordIdx == 5'h1 && t_r.bitCnt == 5'(adc_pkg::STATUS_W - 1)))
    else $error("readback did not restart at the status word");
endmodule

/* verilog/adc_pkg.sv */
package adc_pkg;
  localparam int CHANNELS = 8;
  localparam int STATUS_W = 24;
  localparam int LONG_W = 24;
  localparam int SHORT_W = 16;
  localparam int FLAG_W = 8;
  localparam int SETTLE_HR = 296;
  localparam int SETTLE_LP = 584;
  localparam int RATE_SHIFT_MAX = 6;
  localparam int PERIOD_SHIFT = 2;
  localparam int STOP_TO_READY_LEAD = 16;
  localparam int STOP_TO_FINISH_HOLD = 16;
  localparam int OPCODE_FALL = 6;
  localparam int TRAIL_R0 = 7;
  localparam int TRAIL_R1 = 5;
  localparam logic [2:0] RATE_R0 = 3'h0;
  localparam logic [2:0] RATE_R1 = 3'h1;
  localparam logic [23:0] SAT_MAX = 24'h7fffff;
  localparam logic [23:0] SAT_MIN = 24'h800000;
  localparam logic [6:0] START_OP7 = 7'h04;
  localparam logic [6:0] STOP_OP7 = 7'h05;
  localparam int EV_FELL = 0;
  localparam int EV_START = 1;
  localparam int EV_STOP = 2;
  localparam int EV_PIN = 3;
  typedef enum logic [1:0] {IDLE, CONVERT, WRITE} conv_state_t;

  function automatic logic shortRate(input logic [2:0] rate);
    return (rate == RATE_R0) || (rate == RATE_R1);
  endfunction
endpackage

/* verilog/level_sync.sv */
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] async,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;
  sync_t r_r, r_nxt;

  // A change counts only once the second and third stage agree
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = async;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.lvl[i] = r_r.s3[i];
      end
    end
    if (!reset_n) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign level = r_r.lvl;
endmodule

/* verilog/result_mem.sv */
`timescale 1ns/100ps
module result_mem #(
  parameter int W = 24,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic wrClk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  input wire logic rdClk,
  input wire logic [AW-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge wrClk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read on the falling serial edge so the word is ready before the next launch
  always_ff @(negedge rdClk) begin
    rdData <= mem[rdAddr];
  end
endmodule

/* tb/host_model.sv */
`timescale 1ns/100ps
module host_model #(
  parameter int CH = 8
) (
  output logic sclk,
  output logic csN,
  output logic din,
  input wire logic dout,
  input wire logic doutEn
);
  logic [23:0] rxQ[$];

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end

  // Clock toggles only inside a selected frame, except in the stray task
  // A floating output reads as unknown, so a missing enable never matches
  task automatic pulse(input logic b, output logic got);
    din = b;
    #3;
    sclk = 1'b1;
    #6;
    got = doutEn ? dout : 1'bx;
    sclk = 1'b0;
    #3;
  endtask

  task automatic xfer(input logic [7:0] op);
    logic g;
    csN = 1'b0;
    #5;
    for (int i = 7; i >= 0; i--) pulse(op[i], g);
    #100;
    csN = 1'b1;
    #20;
  endtask

  task automatic read(input int n, input int w);
    logic g;
    logic [23:0] acc;
    csN = 1'b0;
    #5;
    for (int k = 0; k < n; k++) begin
      acc = 24'h000000;
      for (int b = 0; b < ((k % (CH + 1) == 0) ? 24 : w); b++) begin
        pulse(1'b0, g);
        acc = {acc[22:0], g};
      end
      rxQ.push_back(acc);
    end
    #100;
    csN = 1'b1;
    #20;
  endtask

  // Ungated clock while deselected, used on purpose
  task automatic stray();
    #3;
    sclk = 1'b1;
    #6;
    sclk = 1'b0;
    #3;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
  localparam int CH = adc_pkg::CHANNELS;
  localparam int RW = 26;
  localparam logic [RW-1:0] SPEC [5] = '{26'h1000000, 26'h2ffffff, 26'h0000001, 26'h3ffffff,
                                         26'h0000000};
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic sclk, csN, din, dout, doutEn, readyN, filterReset, converting;
  logic startPin = 1'b0;
  logic oneShotSel = 1'b1;
  logic readbackEn = 1'b0;
  logic lowPowerSel = 1'b0;
  logic [2:0] rateSelect = 3'h0;
  logic [7:0] posF = 8'h00;
  logic [7:0] negF = 8'h00;
  logic [7:0] gpio = 8'h00;
  logic [CH*RW-1:0] chanRaw = '0;
  logic [CH-1:0] pdMask = '0;
  logic [23:0] expQ[$];
  logic [23:0] w;
  int badCount = 0;
  int nCompared = 0;

  always #10 clk = ~clk;

  host_model #(.CH(CH)) i_host (.sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn));

  adc_conversion_and_readout #(.CH(CH), .RAW_W(RW), .SETTLE_HR(8), .SETTLE_LP(16)) i_dut (
    .clk(clk), .reset_n(rstN), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn), .resultReadyN(readyN), .startPin(startPin), .oneShotSel(oneShotSel),
    .readbackEn(readbackEn), .lowPowerSel(lowPowerSel), .rateSelect(rateSelect),
    .leadoffPosFlags(posF), .leadoffNegFlags(negF), .gpioStatus(gpio), .chanRaw(chanRaw),
    .chanPowerDown(pdMask), .filterReset(filterReset), .converting(converting));

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic endSim();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait; which: 0 filter reset, 1 ready, 2 converting
  task automatic waitSig(input int which, input logic val, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (((which == 0) ? filterReset : (which == 1) ? readyN : converting) === val) return;
      tick(1);
    end
    badCount++;
    $display("[ERR] wait %0d expected %b seen timeout", which, val);
    endSim();
  endtask

  task automatic startSeen();
    waitSig(0, 1'b1, 60);
    check("converting at start", 24'h1, 24'(converting));
    check("ready at start", 24'h1, 24'(readyN));
    tick(1);
    check("filter reset pulse", 24'h0, 24'(filterReset));
  endtask

  function automatic logic [23:0] sat(input logic [RW-1:0] r);
    if ($signed(r) > $signed(26'h07fffff)) return 24'h7fffff;
    if ($signed(r) < $signed(26'h3800000)) return 24'h800000;
    return r[23:0];
  endfunction

  task automatic oneShot(input logic [2:0] r);
    int wd;
    logic [23:0] x;
    wd = (r < 3'h2) ? 16 : 24;
    rateSelect = r;
    lowPowerSel = r[0];
    readbackEn = (r == 3'h2);
    oneShotSel = 1'b1;
    posF = 8'($urandom);
    negF = 8'($urandom);
    gpio = 8'($urandom);
    pdMask = (8'($urandom) & 8'he0) | 8'h80;
    for (int c = 0; c < CH; c++) begin
      x = 24'($urandom);
      chanRaw[c*RW +: RW] = (c < 5) ? SPEC[c] : {{2{x[23]}}, x};
    end
    if (r[0]) fork
      i_host.xfer({adc_pkg::START_OP7, 1'b0});
      startSeen();
    join
    else begin
      startPin = 1'b1;
      startSeen();
    end
    waitSig(1, 1'b0, 400);
    check("converting after result", 24'h0, 24'(converting));
    startPin = 1'b0;
    tick(30);
    check("ready held", 24'h0, 24'(readyN));
    check("halted", 24'h0, 24'(converting));
    if (r == 3'h3) i_host.stray();
    else begin
      expQ.push_back({posF, negF, gpio});
      for (int c = 0; c < CH; c++) begin
        x = pdMask[c] ? 24'h000000 : sat(chanRaw[c*RW +: RW]);
        expQ.push_back((wd == 16) ? {8'h00, x[23:8]} : x);
      end
      if (readbackEn) expQ.push_back({posF, negF, gpio});
      i_host.read(CH + 1 + int'(readbackEn), wd);
    end
    tick(1);
    waitSig(1, 1'b1, 10);
  endtask

  always @(posedge clk) begin
    while (i_host.rxQ.size() > 0) begin
      w = i_host.rxQ.pop_front();
      if (expQ.size() == 0) begin
        badCount++;
        $display("[ERR] frame word expected none seen %h", w);
      end
      else check("frame word", expQ.pop_front(), w);
    end
  end

  initial begin
    int n;
    void'($urandom(32'hf5b30443));
    tick(10);
    rstN = 1'b1;
    tick(1);
    check("ready after reset", 24'h1, 24'(readyN));
    check("idle after reset", 24'h0, 24'({converting, filterReset}));
    for (int r = 0; r < 4; r++) oneShot(3'(r));
    oneShotSel = 1'b0;
    rateSelect = 3'h0;
    lowPowerSel = 1'b0;
    readbackEn = 1'b0;
    startPin = 1'b1;
    startSeen();
    n = 0;
    for (int i = 0; i < 80; i++) begin
      tick(1);
      n += int'(converting !== 1'b1 || filterReset !== 1'b0);
    end
    check("running while pin high", 24'h0, 24'(n));
    startPin = 1'b0;
    waitSig(2, 1'b0, 40);
    fork
      i_host.xfer({adc_pkg::START_OP7, 1'b0});
      startSeen();
    join
    tick(20);
    check("running after opcode", 24'h1, 24'(converting));
    fork
      i_host.xfer({adc_pkg::STOP_OP7, 1'b0});
      waitSig(2, 1'b0, 60);
    join
    tick(5);
    check("pending words", 24'h0, 24'(expQ.size()));
    endSim();
  end
endmodule
